// *** rtl/pmc_pkg.sv ***
/*
 * Shared constants and types for the periodic match counter: register offsets,
 * control field layout, reset values and the prescaler divide table.
 * Assumes a 32-bit APB register port with byte addressing.
 */
package pmc_pkg;

    // Register byte offsets on the APB port
    localparam logic [11:0] OFS_CTRL  = 12'h000;
    localparam logic [11:0] OFS_COUNT = 12'h004;
    localparam logic [11:0] OFS_LIMIT = 12'h008;

    localparam int          REG_W     = 8;
    localparam int          DIV_W     = 18;

    // Source select codes; code 2'b11 selects the internal reference but uses the divide table of SRC_EXT
    localparam logic [1:0]  SRC_LPO   = 2'b00;
    localparam logic [1:0]  SRC_EXT   = 2'b01;
    localparam logic [3:0]  DIV_OFF   = 4'h0;

    // Control/status byte, bit 7 down to bit 0
    typedef struct packed {
        logic       flag;
        logic [1:0] src_sel;
        logic       irq_en;
        logic [3:0] div_sel;
    } pmc_ctrl_type;

    localparam pmc_ctrl_type RST_CTRL  = '0;
    localparam logic [7:0]   RST_COUNT = 8'h00;
    localparam logic [7:0]   RST_LIMIT = 8'h00;
    localparam logic [17:0]  RST_PRESC = 18'h00000;

    // Divide ratio for a divider code; code 0 is off and never ticks
    function automatic logic [DIV_W-1:0] pmc_div_value(input logic src0, input logic [3:0] code);
        logic [DIV_W-1:0] v;
        v = 18'h00001;
        if (!src0) begin
            case (code)
                4'h1: v = 18'h00008;
                4'h2: v = 18'h00020;
                4'h3: v = 18'h00040;
                4'h4: v = 18'h00080;
                4'h5: v = 18'h00100;
                4'h6: v = 18'h00200;
                4'h7: v = 18'h00400;
                4'h8: v = 18'h00001;
                4'h9: v = 18'h00002;
                4'ha: v = 18'h00004;
                4'hb: v = 18'h0000a;
                4'hc: v = 18'h00010;
                4'hd: v = 18'h00064;
                4'he: v = 18'h001f4;
                4'hf: v = 18'h003e8;
                default: v = 18'h00001;
            endcase
        end else begin
            case (code)
                4'h1: v = 18'h00400;
                4'h2: v = 18'h00800;
                4'h3: v = 18'h01000;
                4'h4: v = 18'h02000;
                4'h5: v = 18'h04000;
                4'h6: v = 18'h08000;
                4'h7: v = 18'h10000;
                4'h8: v = 18'h003e8;
                4'h9: v = 18'h007d0;
                4'ha: v = 18'h01388;
                4'hb: v = 18'h02710;
                4'hc: v = 18'h04e20;
                4'hd: v = 18'h0c350;
                4'he: v = 18'h186a0;
                4'hf: v = 18'h30d40;
                default: v = 18'h00001;
            endcase
        end
        return v;
    endfunction : pmc_div_value

endpackage : pmc_pkg

// *** rtl/pmc_counter.sv ***
/*
 * Periodic match counter: three source clocks, binary/decimal prescaler,
 * 8-bit up-counter with match limit, sticky match flag and interrupt.
 * Assumes an APB master on pclk; the three source clocks are asynchronous
 * levels, each far slower than pclk/2 so every edge is seen after sync.
 */
`timescale 1ns/100ps
module pmc_counter #(
    parameter int ADDR_W = 12
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              low_power_osc_clock,
    input  wire logic              external_ref_clock,
    input  wire logic              internal_ref_clock,
    input  wire logic              debug_halt,
    input  wire logic              deep_stop,
    output logic                   irq
);

    initial begin
        if (ADDR_W < 4 || ADDR_W > 12) begin
            $error("pmc_counter: ADDR_W must be 4 to 12");
        end
    end

    pmc_pkg::pmc_ctrl_type   ctrl_reg,  ctrl_next;
    logic [7:0]              count_reg, count_next;
    logic [7:0]              limit_reg, limit_next;
    logic [17:0]             presc_reg, presc_next;
    logic [31:0]             prdata_reg, prdata_next;
    logic [2:0]              src_meta_reg;
    logic [2:0]              src_sync_reg;
    logic                    sel_prev_reg, sel_prev_next;
    logic                    sel_level;
    logic                    src_edge;
    logic                    tick;
    logic                    running;
    logic                    set_flag;
    logic                    cfg_clear;
    logic [17:0]             div_now;
    logic [11:0]             addr;
    logic                    mapped;
    logic                    wr_acc;
    logic                    rd_setup;
    pmc_pkg::pmc_ctrl_type   wr_ctrl;

    assign addr     = 12'(paddr);
    assign mapped   = (addr == pmc_pkg::OFS_CTRL) || (addr == pmc_pkg::OFS_COUNT) ||
                      (addr == pmc_pkg::OFS_LIMIT);
    // A frozen block must not complete a transfer, so ready follows the enable
    assign pready   = ce;
    assign pslverr  = psel && penable && !mapped;
    assign wr_acc   = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable && !pwrite;
    assign wr_ctrl  = pmc_pkg::pmc_ctrl_type'(pwdata[7:0]);
    assign prdata   = prdata_reg;

    // Two-stage synchronisers; only the second stage is looked at
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_meta_reg <= 3'h0;
            src_sync_reg <= 3'h0;
        end else if (ce) begin
            src_meta_reg <= {internal_ref_clock, external_ref_clock, low_power_osc_clock};
            src_sync_reg <= src_meta_reg;
        end
    end

    // Source mux; in deep stop only the oscillator keeps running
    always_comb begin
        if (ctrl_reg.src_sel == pmc_pkg::SRC_LPO) begin
            sel_level = src_sync_reg[0];
        end else if (deep_stop) begin
            sel_level = 1'b0;
        end else if (ctrl_reg.src_sel == pmc_pkg::SRC_EXT) begin
            sel_level = src_sync_reg[1];
        end else begin
            sel_level = src_sync_reg[2];
        end
    end

    assign div_now  = pmc_pkg::pmc_div_value(ctrl_reg.src_sel[0], ctrl_reg.div_sel);
    assign src_edge = sel_level && !sel_prev_reg;
    // Wait and stop leave this running; only debug halt or divider code 0 suspends it
    assign running  = (ctrl_reg.div_sel != 4'(pmc_pkg::DIV_OFF)) && !debug_halt;
    assign tick     = src_edge && running && (presc_reg == div_now - 18'h00001);

    always_comb begin
        ctrl_next     = ctrl_reg;
        count_next    = count_reg;
        limit_next    = limit_reg;
        presc_next    = presc_reg;
        sel_prev_next = sel_level;
        set_flag      = 1'b0;
        cfg_clear     = 1'b0;
        prdata_next   = prdata_reg;

        if (src_edge && running) begin
            presc_next = tick ? pmc_pkg::RST_PRESC : presc_reg + 18'h00001;
        end
        if (tick) begin
            if (count_reg == limit_reg) begin
                count_next = pmc_pkg::RST_COUNT;
                set_flag   = 1'b1;
            end else begin
                count_next = count_reg + 8'h01;
            end
        end

        if (wr_acc && addr == pmc_pkg::OFS_CTRL) begin
            if (wr_ctrl.src_sel != ctrl_reg.src_sel) begin
                cfg_clear = 1'b1;
            end
            if (wr_ctrl.div_sel != ctrl_reg.div_sel) begin
                cfg_clear = 1'b1;
            end
            ctrl_next.src_sel = wr_ctrl.src_sel;
            ctrl_next.irq_en  = wr_ctrl.irq_en;
            ctrl_next.div_sel = wr_ctrl.div_sel;
            if (wr_ctrl.flag) begin
                ctrl_next.flag = 1'b0;
            end
        end
        if (wr_acc && addr == pmc_pkg::OFS_LIMIT) begin
            limit_next = pwdata[7:0];
            cfg_clear  = 1'b1;
        end
        // Writes to the count offset are accepted and dropped

        // A match in the clearing cycle still lands: set beats clear
        if (set_flag) begin
            ctrl_next.flag = 1'b1;
        end
        if (cfg_clear) begin
            presc_next = pmc_pkg::RST_PRESC;
            count_next = pmc_pkg::RST_COUNT;
        end

        // Read data is captured in the setup phase and held for the access
        if (rd_setup) begin
            prdata_next = 32'h00000000;
            if (addr == pmc_pkg::OFS_CTRL) begin
                prdata_next[7:0] = ctrl_reg;
            end else if (addr == pmc_pkg::OFS_COUNT) begin
                prdata_next[7:0] = count_reg;
            end else if (addr == pmc_pkg::OFS_LIMIT) begin
                prdata_next[7:0] = limit_reg;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg     <= pmc_pkg::RST_CTRL;
            count_reg    <= pmc_pkg::RST_COUNT;
            limit_reg    <= pmc_pkg::RST_LIMIT;
            presc_reg    <= pmc_pkg::RST_PRESC;
            sel_prev_reg <= 1'b0;
            prdata_reg   <= 32'h00000000;
        end else if (ce) begin
            ctrl_reg     <= ctrl_next;
            count_reg    <= count_next;
            limit_reg    <= limit_next;
            presc_reg    <= presc_next;
            sel_prev_reg <= sel_prev_next;
            prdata_reg   <= prdata_next;
        end
    end

    // Level request; the flag bit acts as the sticky status, enable as mask
    assign irq = ctrl_reg.flag && ctrl_reg.irq_en;

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence match_tick_seq;
        ce && tick && (count_reg == limit_reg) && !cfg_clear;
    endsequence

    sequence flag_clear_write_seq;
        ce && wr_acc && (addr == pmc_pkg::OFS_CTRL) && wr_ctrl.flag && !set_flag;
    endsequence

    sequence cfg_change_seq;
        ce && wr_acc && (addr == pmc_pkg::OFS_CTRL) &&
        ((wr_ctrl.src_sel != ctrl_reg.src_sel) || (wr_ctrl.div_sel != ctrl_reg.div_sel));
    endsequence

    chk_flag_on_wrap: assert property (match_tick_seq |=> ctrl_reg.flag && count_reg == 8'h00)
        else $error("match did not wrap count and set flag");

    chk_flag_w1c_clear: assert property (flag_clear_write_seq |=> !ctrl_reg.flag && !irq)
        else $error("write one did not clear flag");

    chk_flag_w0_keep: assert property (ce && wr_acc && addr == pmc_pkg::OFS_CTRL && !wr_ctrl.flag && ctrl_reg.flag
        |=> ctrl_reg.flag)
        else $error("write zero changed flag");

    chk_reset_state: assert property (disable iff (1'b0) !presetn |-> count_reg == 8'h00 &&
        limit_reg == 8'h00 && ctrl_reg == pmc_pkg::RST_CTRL && !irq)
        else $error("reset state wrong");

    chk_src_lpo_path: assert property (ctrl_reg.src_sel == pmc_pkg::SRC_LPO |-> sel_level == src_sync_reg[0])
        else $error("oscillator not selected");

    chk_cfg_change_clr: assert property (cfg_change_seq |=> count_reg == 8'h00 && presc_reg == 18'h00000)
        else $error("config change did not clear counters");

    chk_div_off_still: assert property (ctrl_reg.div_sel == 4'h0 && !wr_acc |=> $stable(count_reg))
        else $error("count moved with prescaler off");

    chk_tick_period: assert property (tick |-> presc_reg == div_now - 18'h00001 && div_now != 18'h00000)
        else $error("prescaler tick at wrong count");

    chk_count_step: assert property (ce && tick && count_reg != limit_reg && !cfg_clear
        |=> count_reg == $past(count_reg) + 8'h01)
        else $error("count did not advance by one");

    chk_limit_write_clr: assert property (ce && wr_acc && addr == pmc_pkg::OFS_LIMIT
        |=> count_reg == 8'h00 && presc_reg == 18'h00000 && limit_reg == $past(pwdata[7:0]))
        else $error("limit write did not clear counters");

    chk_count_ro: assert property (ce && wr_acc && addr == pmc_pkg::OFS_COUNT && !tick
        |=> count_reg == $past(count_reg))
        else $error("count write changed count");

    chk_irq_follow: assert property ($rose(ctrl_reg.flag) && ctrl_reg.irq_en |-> irq ##1 (irq || !ctrl_reg.flag))
        else $error("interrupt did not follow flag");

    chk_debug_hold: assert property (debug_halt && !wr_acc [*2] |-> $stable(count_reg) && $stable(presc_reg))
        else $error("counting during debug halt");

    // Interrupt output
    chk_irq_masked: assert property (!ctrl_reg.irq_en |-> !irq)
        else $error("interrupt raised while disabled");

    chk_irq_needs_flag: assert property (!ctrl_reg.flag |-> !irq)
        else $error("interrupt raised without flag");

    chk_irq_level: assert property (ctrl_reg.flag && ctrl_reg.irq_en |-> irq)
        else $error("interrupt missing while flag enabled");

    // Register interface
    chk_ready_ce: assert property (pready == ce)
        else $error("ready does not follow enable");

    chk_err_unmapped: assert property (psel && penable && !mapped |-> pslverr)
        else $error("unmapped access without error");

    chk_err_access_only: assert property (pslverr |-> psel && penable && !mapped)
        else $error("error outside unmapped access");

    chk_rdata_upper: assert property (prdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");

    chk_rd_ctrl_data: assert property (ce && rd_setup && addr == pmc_pkg::OFS_CTRL
        |=> prdata[7:0] == $past(ctrl_reg))
        else $error("control read data wrong");

    chk_rd_count_data: assert property (ce && rd_setup && addr == pmc_pkg::OFS_COUNT
        |=> prdata[7:0] == $past(count_reg))
        else $error("count read data wrong");

    chk_rd_limit_data: assert property (ce && rd_setup && addr == pmc_pkg::OFS_LIMIT
        |=> prdata[7:0] == $past(limit_reg))
        else $error("limit read data wrong");

    chk_rd_unmapped_zero: assert property (ce && rd_setup && !mapped |=> prdata == 32'h00000000)
        else $error("unmapped read data not zero");

    chk_ctrl_write_lands: assert property (ce && wr_acc && addr == pmc_pkg::OFS_CTRL
        |=> ctrl_reg.src_sel == $past(wr_ctrl.src_sel) && ctrl_reg.div_sel == $past(wr_ctrl.div_sel) &&
        ctrl_reg.irq_en == $past(wr_ctrl.irq_en))
        else $error("control write lost");

    chk_unmapped_no_wr: assert property (ce && psel && penable && pwrite && !mapped |=> $stable(limit_reg))
        else $error("unmapped write changed limit");

    chk_limit_hold: assert property (!(ce && wr_acc && addr == pmc_pkg::OFS_LIMIT)
        |=> $stable(limit_reg))
        else $error("limit changed without write");

    // Source path and synchronisers
    chk_sync_stage: assert property (ce |=> src_sync_reg == $past(src_meta_reg))
        else $error("synchroniser second stage skipped");

    chk_src_ext_path: assert property (!deep_stop && ctrl_reg.src_sel == pmc_pkg::SRC_EXT
        |-> sel_level == src_sync_reg[1])
        else $error("external reference not selected");

    chk_src_int_path: assert property (!deep_stop && ctrl_reg.src_sel[1]
        |-> sel_level == src_sync_reg[2])
        else $error("internal reference not selected");

    chk_deep_stop_gate: assert property (deep_stop && ctrl_reg.src_sel != pmc_pkg::SRC_LPO
        |-> !sel_level)
        else $error("gated source active in deep stop");

    chk_deep_stop_lpo: assert property (deep_stop && ctrl_reg.src_sel == pmc_pkg::SRC_LPO
        |-> sel_level == src_sync_reg[0])
        else $error("oscillator lost in deep stop");

    // Prescaler and counter
    chk_no_tick_halted: assert property (debug_halt |-> !tick)
        else $error("tick during debug halt");

    chk_no_tick_off: assert property (ctrl_reg.div_sel == 4'(pmc_pkg::DIV_OFF) |-> !tick)
        else $error("tick with prescaler off");

    chk_presc_bound: assert property (presc_reg < div_now)
        else $error("prescaler beyond divide value");

    chk_presc_step: assert property (ce && src_edge && running && !tick && !cfg_clear
        |=> presc_reg == $past(presc_reg) + 18'h00001)
        else $error("prescaler did not advance");

    chk_presc_wrap: assert property (ce && tick && !cfg_clear |=> presc_reg == pmc_pkg::RST_PRESC)
        else $error("prescaler did not wrap at tick");

    chk_presc_idle: assert property (ce && !(src_edge && running) && !cfg_clear
        |=> $stable(presc_reg))
        else $error("prescaler moved without source edge");

    chk_count_hold: assert property (ce && !tick && !cfg_clear |=> $stable(count_reg))
        else $error("count moved without tick");

    chk_same_cfg_keep: assert property (ce && wr_acc && addr == pmc_pkg::OFS_CTRL && !tick &&
        wr_ctrl.src_sel == ctrl_reg.src_sel && wr_ctrl.div_sel == ctrl_reg.div_sel
        |=> $stable(count_reg))
        else $error("unchanged setting cleared count");

    chk_ce_freeze: assert property (!ce |=> $stable(count_reg) && $stable(presc_reg) && $stable(ctrl_reg) &&
        $stable(limit_reg))
        else $error("state moved while disabled");

    // Match flag
    chk_flag_sticky: assert property (ctrl_reg.flag &&
        !(wr_acc && addr == pmc_pkg::OFS_CTRL && wr_ctrl.flag) |=> ctrl_reg.flag)
        else $error("flag cleared without write one");

    chk_flag_no_spurious: assert property (ce && !set_flag && !ctrl_reg.flag |=> !ctrl_reg.flag)
        else $error("flag set without match");

    chk_set_beats_clear: assert property (ce && set_flag |=> ctrl_reg.flag)
        else $error("match lost against clear");

    chk_wrap_only_at_limit: assert property (ce && tick && count_reg != limit_reg && !cfg_clear
        |=> !ctrl_reg.flag || $past(ctrl_reg.flag))
        else $error("flag set before limit reached");

endmodule : pmc_counter

// *** dv/periodic_match_counter_bench.sv ***
/*
 * Self-checking bench for the periodic match counter: APB register access,
 * source pins toggled slowly enough for the synchronisers, flag and irq checks.
 * Assumes pmc_counter answers APB with zero wait states while ce is high.
 */
`timescale 1ns/100ps
module periodic_match_counter_bench;
    logic        pclk       = 1'b0;
    logic        presetn    = 1'b0;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [11:0] paddr      = 12'h000;
    logic [31:0] pwdata     = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  src_pins   = 3'h0;
    logic        debug_halt = 1'b0;
    logic        ce         = 1'b1;
    logic        deep_stop  = 1'b0;
    logic        irq;
    logic [31:0] rd_data;
    logic        rd_err;
    int          error_cnt  = 0;
    int          n_checks   = 0;

    always #5 pclk = ~pclk;

    pmc_counter #(.ADDR_W(12)) i_dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .low_power_osc_clock(src_pins[0]), .external_ref_clock(src_pins[1]),
        .internal_ref_clock(src_pins[2]), .debug_halt(debug_halt), .deep_stop(deep_stop), .irq(irq));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // The bench watchdog ends a hang, so the wait needs no count of its own
        do @(posedge pclk); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err  = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic rd_check(input logic [11:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        check(nm, rd_data, exp);
    endtask : rd_check

    function automatic logic [31:0] ctl(input logic f, input logic [1:0] s, input logic ie, input logic [3:0] d);
        return {24'h0, f, s, ie, d};
    endfunction : ctl

    // Each edge is 3 pclk high and 4 low: slower than the synchroniser needs
    task automatic edges(input int idx, input int n);
        repeat (n) begin
            @(posedge pclk); src_pins[idx] <= 1'b1;
            repeat (3) @(posedge pclk);
            src_pins[idx] <= 1'b0;
            repeat (3) @(posedge pclk);
        end
        repeat (5) @(posedge pclk);
    endtask : edges

    task automatic start(input logic [1:0] s, input logic [3:0] d, input logic [7:0] lim);
        apb(1'b1, pmc_pkg::OFS_CTRL, ctl(1'b1, s, 1'b0, d));
        apb(1'b1, pmc_pkg::OFS_LIMIT, {24'h0, lim});
    endtask : start

    task automatic test_reset;
        rd_check(pmc_pkg::OFS_CTRL, 32'h0, "ctrl");
        rd_check(pmc_pkg::OFS_LIMIT, 32'h0, "limit");
        check("irq", {31'h0, irq}, 32'h0);
        edges(0, 3);
        rd_check(pmc_pkg::OFS_COUNT, 32'h0, "count");
        $display("test_reset done");
    endtask : test_reset

    task automatic test_match;
        start(2'b00, 4'h8, 8'h03);
        edges(0, 2);
        @(posedge pclk); debug_halt <= 1'b1;
        edges(0, 2);
        rd_check(pmc_pkg::OFS_COUNT, 32'h2, "count");
        @(posedge pclk); debug_halt <= 1'b0;
        edges(0, 1);
        rd_check(pmc_pkg::OFS_COUNT, 32'h3, "count");
        rd_check(pmc_pkg::OFS_CTRL, ctl(1'b0, 2'b00, 1'b0, 4'h8), "ctrl");
        edges(0, 1);
        rd_check(pmc_pkg::OFS_COUNT, 32'h0, "count");
        rd_check(pmc_pkg::OFS_CTRL, ctl(1'b1, 2'b00, 1'b0, 4'h8), "ctrl");
        check("irq", {31'h0, irq}, 32'h0);
        apb(1'b1, pmc_pkg::OFS_CTRL, ctl(1'b0, 2'b00, 1'b1, 4'h8));
        rd_check(pmc_pkg::OFS_CTRL, ctl(1'b1, 2'b00, 1'b1, 4'h8), "ctrl");
        check("irq", {31'h0, irq}, 32'h1);
        apb(1'b1, pmc_pkg::OFS_CTRL, ctl(1'b1, 2'b00, 1'b1, 4'h8));
        @(posedge pclk);
        check("irq", {31'h0, irq}, 32'h0);
        rd_check(pmc_pkg::OFS_CTRL, ctl(1'b0, 2'b00, 1'b1, 4'h8), "ctrl");
        $display("test_match done");
    endtask : test_match

    task automatic test_divides;
        logic [1:0] s_t[5] = '{2'b00, 2'b00, 2'b01, 2'b10, 2'b11};
        logic [3:0] c_t[5] = '{4'h9, 4'h1, 4'h8, 4'hb, 4'h1};
        int         n_t[5] = '{2, 8, 1000, 10, 1024};
        int         pin;
        for (int i = 0; i < 5; i++) begin
            pin = (s_t[i] == 2'b00) ? 0 : ((s_t[i] == 2'b01) ? 1 : 2);
            start(s_t[i], c_t[i], 8'h00);
            edges((pin + 1) % 3, 2);
            edges(pin, n_t[i] - 1);
            rd_check(pmc_pkg::OFS_CTRL, ctl(1'b0, s_t[i], 1'b0, c_t[i]), "ctrl");
            edges(pin, 1);
            rd_check(pmc_pkg::OFS_CTRL, ctl(1'b1, s_t[i], 1'b0, c_t[i]), "ctrl");
        end
        $display("test_divides done");
    endtask : test_divides

    task automatic test_clears;
        start(2'b00, 4'h8, 8'h0a);
        edges(0, 3);
        apb(1'b1, pmc_pkg::OFS_COUNT, 32'h000000ff);
        rd_check(pmc_pkg::OFS_COUNT, 32'h3, "count");
        apb(1'b1, pmc_pkg::OFS_CTRL, ctl(1'b0, 2'b00, 1'b0, 4'h9));
        rd_check(pmc_pkg::OFS_COUNT, 32'h0, "count");
        edges(0, 4);
        rd_check(pmc_pkg::OFS_COUNT, 32'h2, "count");
        apb(1'b1, pmc_pkg::OFS_CTRL, ctl(1'b0, 2'b10, 1'b0, 4'h9));
        rd_check(pmc_pkg::OFS_COUNT, 32'h0, "count");
        edges(2, 2);
        apb(1'b1, pmc_pkg::OFS_LIMIT, 32'h0000000a);
        rd_check(pmc_pkg::OFS_COUNT, 32'h0, "count");
        rd_check(pmc_pkg::OFS_LIMIT, 32'ha, "limit");
        apb(1'b0, 12'h00c, 32'h0);
        check("unmapped err", {31'h0, rd_err}, 32'h1);
        $display("test_clears done");
    endtask : test_clears

    task automatic test_stop;
        start(2'b10, 4'h8, 8'h0a);
        edges(2, 2);
        @(posedge pclk); deep_stop <= 1'b1;
        edges(2, 2);
        rd_check(pmc_pkg::OFS_COUNT, 32'h2, "count");
        apb(1'b1, pmc_pkg::OFS_CTRL, ctl(1'b0, 2'b00, 1'b0, 4'h8));
        edges(0, 3);
        rd_check(pmc_pkg::OFS_COUNT, 32'h3, "count");
        @(posedge pclk); deep_stop <= 1'b0; ce <= 1'b0;
        edges(0, 2);
        @(posedge pclk); ce <= 1'b1;
        rd_check(pmc_pkg::OFS_COUNT, 32'h3, "count");
        $display("test_stop done");
    endtask : test_stop

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    // Longest test is about 15k cycles; the limit leaves ample margin
    initial begin
        repeat (60000) @(posedge pclk);
        error_cnt++;
        stop_test();
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_match();
        test_divides();
        test_clears();
        test_stop();
        stop_test();
    end
endmodule : periodic_match_counter_bench
